// ===== hdl/pdlr_defines.svh
// constants for the peripheral disable and lock register block
// assumes a single clock domain and byte-wide register strobes
// Summary of operation
// - host copy sits at runtime offset 0x22, host port only.
// - bits 3, 5, 6 and 7 disable peripherals, bit 0 is floppy write protect.
// - writing lock bit 1 high makes the whole copy read-only.
// - software cannot clear the lock; only the three resets do.
// - with lock low the lock adds no write restriction.
// - guard config bits [3:2] written 01 select the write guard input.
// - once at 01, guard select bits cannot be changed by writes, only by resets.
// - guard selected: pin high makes host copy read-only, low read/write.
// - lock high always read-only; lock and guard enable low, read/write.
// - identical slave copy sits at offset 01h, slave port only.
// - the guard pin never restricts the slave copy.
// - a peripheral is enabled only when neither copy disables it.
// - each lock bit guards only its own copy.
// - once locked, disable bits return to enabled only through reset.
`ifndef PDLR_DEFINES_SVH
`define PDLR_DEFINES_SVH
`define PDLR_HOST_DIS_OFS 8'h22
`define PDLR_GUARD_CFG_OFS 8'h40
`define PDLR_SLV_DIS_OFS 8'h01
`define PDLR_DIS_MASK 8'hEB
`define PDLR_DIS_RST 8'h00
`define PDLR_GUARD_SEL_MSB 3
`define PDLR_GUARD_SEL_LSB 2
`define PDLR_GUARD_SEL_ON 2'h1
`define PDLR_GUARD_RST 2'h0
`define PDLR_RDATA_RST 8'h00
`define PDLR_EN_RST 1'b1
`endif

// ===== hdl/pdlr_pkg.sv
// types shared by the disable register copies and the top
// assumes pdlr_defines.svh for all numeric constants
`default_nettype none
package pdlr_pkg;
  // one register access strobe group, single cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdlr_req_t;

  // disable register layout, bit 7 down to bit 0
  typedef struct packed {
    logic par_dis;
    logic ser2_dis;
    logic ser1_dis;
    logic rsvd4;
    logic fdc_dis;
    logic rsvd2;
    logic lock;
    logic fdc_wp;
  } pdlr_dis_t;
endpackage : pdlr_pkg
`default_nettype wire

// ===== hdl/pdlr_dis_copy.sv
// one peripheral disable register copy with its sticky lock
// assumes write strobe already decoded and reset pulses synchronous
`include "pdlr_defines.svh"
`default_nettype none
module pdlr_dis_copy (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_ext_block,
  output pdlr_pkg::pdlr_dis_t o_q,
  output logic o_read_only
);
  pdlr_pkg::pdlr_dis_t q;
  pdlr_pkg::pdlr_dis_t next_q;

  assign o_read_only = q.lock | i_ext_block;
  assign o_q = q;

  always_comb begin
    next_q = q;
    if (i_clr) begin
      next_q = pdlr_pkg::pdlr_dis_t'(`PDLR_DIS_RST);
    end else if (i_wr && !o_read_only) begin
      next_q = pdlr_pkg::pdlr_dis_t'(i_wdata & `PDLR_DIS_MASK);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= pdlr_pkg::pdlr_dis_t'(`PDLR_DIS_RST);
    end else begin
      q <= next_q;
    end
  end
endmodule : pdlr_dis_copy
`default_nettype wire

// ===== hdl/pdlr_top.sv
// peripheral disable registers: host copy, slave port copy, guard config
// assumes requests are one-cycle strobes synchronous to I_SYS_CLK
`include "pdlr_defines.svh"
`default_nettype none
module pdlr_top (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_STANDBY_RAIL_POR,
  input wire logic I_VCC_POR,
  input wire logic I_PCI_RESET,
  input wire pdlr_pkg::pdlr_req_t I_HOST_REQ,
  input wire pdlr_pkg::pdlr_req_t I_SLV_REQ,
  input wire logic I_WRITE_GUARD_INPUT_PIN,
  output logic [7:0] O_HOST_RDATA,
  output logic O_HOST_RVALID,
  output logic [7:0] O_SLV_RDATA,
  output logic O_SLV_RVALID,
  output logic O_FDC_EN,
  output logic O_SER1_EN,
  output logic O_SER2_EN,
  output logic O_PAR_EN,
  output logic O_FDC_WP,
  output logic O_HOST_RO,
  output logic O_SLV_RO
);
  function automatic logic req_hit(input pdlr_pkg::pdlr_req_t r, input logic [7:0] ofs);
    req_hit = (r.addr == ofs);
  endfunction : req_hit

  logic clr;
  logic guard_on;
  logic guard_block;
  logic host_dis_wr;
  logic slv_dis_wr;
  logic host_cfg_wr;
  logic host_ro;
  logic slv_ro;
  logic [1:0] guard_sel;
  logic [1:0] next_guard_sel;
  pdlr_pkg::pdlr_dis_t host_q;
  pdlr_pkg::pdlr_dis_t slv_q;
  logic [7:0] next_host_rdata;
  logic next_host_rvalid;
  logic [7:0] next_slv_rdata;
  logic next_slv_rvalid;
  logic next_fdc_en;
  logic next_ser1_en;
  logic next_ser2_en;
  logic next_par_en;
  logic next_fdc_wp;

  // any of the three system resets clears the whole block
  assign clr = I_STANDBY_RAIL_POR | I_VCC_POR | I_PCI_RESET;
  assign host_dis_wr = I_HOST_REQ.wr && req_hit(I_HOST_REQ, `PDLR_HOST_DIS_OFS);
  assign host_cfg_wr = I_HOST_REQ.wr && req_hit(I_HOST_REQ, `PDLR_GUARD_CFG_OFS);
  assign slv_dis_wr = I_SLV_REQ.wr && req_hit(I_SLV_REQ, `PDLR_SLV_DIS_OFS);
  assign guard_on = (guard_sel == `PDLR_GUARD_SEL_ON);
  assign guard_block = guard_on & I_WRITE_GUARD_INPUT_PIN;

  pdlr_dis_copy u_host (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_clr(clr),
    .i_wr(host_dis_wr),
    .i_wdata(I_HOST_REQ.wdata),
    .i_ext_block(guard_block),
    .o_q(host_q),
    .o_read_only(host_ro)
  );

  pdlr_dis_copy u_slv (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_clr(clr),
    .i_wr(slv_dis_wr),
    .i_wdata(I_SLV_REQ.wdata),
    .i_ext_block(1'b0),
    .o_q(slv_q),
    .o_read_only(slv_ro)
  );

  always_comb begin
    next_guard_sel = guard_sel;
    if (clr) begin
      next_guard_sel = `PDLR_GUARD_RST;
    end else if (host_cfg_wr && !guard_on) begin
      next_guard_sel = I_HOST_REQ.wdata[`PDLR_GUARD_SEL_MSB:`PDLR_GUARD_SEL_LSB];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      guard_sel <= `PDLR_GUARD_RST;
    end else begin
      guard_sel <= next_guard_sel;
    end
  end

  // read path; unmapped offsets read zero
  always_comb begin
    next_host_rdata = `PDLR_RDATA_RST;
    next_slv_rdata = `PDLR_RDATA_RST;
    next_host_rvalid = I_HOST_REQ.rd;
    next_slv_rvalid = I_SLV_REQ.rd;
    if (I_HOST_REQ.rd && req_hit(I_HOST_REQ, `PDLR_HOST_DIS_OFS)) begin
      next_host_rdata = host_q;
    end else if (I_HOST_REQ.rd && req_hit(I_HOST_REQ, `PDLR_GUARD_CFG_OFS)) begin
      next_host_rdata[`PDLR_GUARD_SEL_MSB:`PDLR_GUARD_SEL_LSB] = guard_sel;
    end
    if (I_SLV_REQ.rd && req_hit(I_SLV_REQ, `PDLR_SLV_DIS_OFS)) begin
      next_slv_rdata = slv_q;
    end
  end

  always_comb begin
    next_fdc_en = !(host_q.fdc_dis | slv_q.fdc_dis);
    next_ser1_en = !(host_q.ser1_dis | slv_q.ser1_dis);
    next_ser2_en = !(host_q.ser2_dis | slv_q.ser2_dis);
    next_par_en = !(host_q.par_dis | slv_q.par_dis);
    // write protect also from either copy
    next_fdc_wp = host_q.fdc_wp | slv_q.fdc_wp;
  end

  // outputs lag the registers by one cycle, kept flop-driven
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HOST_RDATA <= `PDLR_RDATA_RST;
      O_HOST_RVALID <= 1'b0;
      O_SLV_RDATA <= `PDLR_RDATA_RST;
      O_SLV_RVALID <= 1'b0;
      O_FDC_EN <= `PDLR_EN_RST;
      O_SER1_EN <= `PDLR_EN_RST;
      O_SER2_EN <= `PDLR_EN_RST;
      O_PAR_EN <= `PDLR_EN_RST;
      O_FDC_WP <= 1'b0;
      O_HOST_RO <= 1'b0;
      O_SLV_RO <= 1'b0;
    end else begin
      O_HOST_RDATA <= next_host_rdata;
      O_HOST_RVALID <= next_host_rvalid;
      O_SLV_RDATA <= next_slv_rdata;
      O_SLV_RVALID <= next_slv_rvalid;
      O_FDC_EN <= next_fdc_en;
      O_SER1_EN <= next_ser1_en;
      O_SER2_EN <= next_ser2_en;
      O_PAR_EN <= next_par_en;
      O_FDC_WP <= next_fdc_wp;
      O_HOST_RO <= host_ro;
      O_SLV_RO <= slv_ro;
    end
  end

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_host_dis_write;
    host_dis_wr && !clr;
  endsequence

  sequence s_slv_dis_write;
    slv_dis_wr && !clr;
  endsequence

  a_host_lock_hold: assert property (
    (host_q.lock && !clr) |=> $stable(host_q)
  ) else $error("host copy changed while locked");

  a_lock_no_clear: assert property (
    (host_q.lock && !clr) ##1 !clr |-> host_q.lock
  ) else $error("host lock dropped without reset");

  a_open_host_write: assert property (
    (s_host_dis_write and (!host_q.lock && !guard_block))
      |=> (host_q == pdlr_pkg::pdlr_dis_t'($past(I_HOST_REQ.wdata) & `PDLR_DIS_MASK))
  ) else $error("open host write not stored");

  a_guard_select: assert property (
    (host_cfg_wr && !clr && !guard_on
      && I_HOST_REQ.wdata[`PDLR_GUARD_SEL_MSB:`PDLR_GUARD_SEL_LSB] == `PDLR_GUARD_SEL_ON)
      |=> guard_on
  ) else $error("guard select not taken");

  a_guard_sticky: assert property (
    (guard_on && !clr) |=> guard_on
  ) else $error("guard select cleared by write");

  a_guard_blocks: assert property (
    (s_host_dis_write and guard_on and I_WRITE_GUARD_INPUT_PIN) |=> $stable(host_q)
  ) else $error("guarded host write took effect");

  a_slave_unguarded: assert property (
    (s_slv_dis_write and !slv_q.lock)
      |=> (slv_q == pdlr_pkg::pdlr_dis_t'($past(I_SLV_REQ.wdata) & `PDLR_DIS_MASK))
  ) else $error("slave write blocked");

  a_enable_and: assert property (
    ##1 (O_SER1_EN == !($past(host_q.ser1_dis) | $past(slv_q.ser1_dis)))
      && (O_PAR_EN == !($past(host_q.par_dis) | $past(slv_q.par_dis)))
  ) else $error("enable not the and of both copies");

  a_host_read_map: assert property (
    (I_HOST_REQ.rd && req_hit(I_HOST_REQ, `PDLR_HOST_DIS_OFS))
      |=> O_HOST_RVALID && (O_HOST_RDATA == $past(host_q))
  ) else $error("host read of disable copy wrong");

  a_slave_read_map: assert property (
    (I_SLV_REQ.rd && req_hit(I_SLV_REQ, `PDLR_SLV_DIS_OFS))
      |=> O_SLV_RVALID && (O_SLV_RDATA == $past(slv_q))
  ) else $error("slave read of disable copy wrong");

  a_reset_clears: assert property (
    clr |=> (!host_q.lock && !slv_q.lock && !host_q.fdc_dis && !slv_q.par_dis)
  ) else $error("system reset did not clear copies");
endmodule : pdlr_top
`default_nettype wire

// ===== tb/pdlr_bus_model.sv
// host and slave port master model, one byte per access
// assumes xfer is called at a falling clock edge
`default_nettype none
module pdlr_bus_model (
  input wire logic i_clk,
  input wire logic [7:0] i_host_rdata,
  input wire logic i_host_rvalid,
  input wire logic [7:0] i_slv_rdata,
  input wire logic i_slv_rvalid,
  output var pdlr_pkg::pdlr_req_t o_host_req,
  output var pdlr_pkg::pdlr_req_t o_slv_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_host_req = '0;
    o_slv_req = '0;
  end
  // released address and data show their inverse, not a stale copy
  task automatic xfer(input bit slv, input bit wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    pdlr_pkg::pdlr_req_t r;
    r = '{wr: wr, rd: !wr, addr: a, wdata: d};
    if (slv) o_slv_req = r;
    else o_host_req = r;
    @(negedge i_clk);
    q = slv ? i_slv_rdata : i_host_rdata;
    v = slv ? i_slv_rvalid : i_host_rvalid;
    r = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    if (slv) o_slv_req = r;
    else o_host_req = r;
    // idle cycle, so back-to-back calls never reassign the request in one step
    @(negedge i_clk);
  endtask : xfer
endmodule : pdlr_bus_model
`default_nettype wire

// ===== tb/pdlr_top_tb.sv
// self-checking bench for the disable register block
// assumes pdlr_bus_model drives both request ports
`default_nettype none
module pdlr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] sres = 3'h0;
  logic pin = 1'b0;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'h0000_e11d;
  logic [7:0] q, hv, sv, w, hrd, srd;
  logic v, hrv, srv, fen, s1en, s2en, pen, wp, hro, sro;
  pdlr_pkg::pdlr_req_t hreq, sreq;
  wire [7:0] outs = {pen, s2en, s1en, fen, wp, hro, sro, hrv | srv};
  always #10 clk = ~clk;
  pdlr_top uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_STANDBY_RAIL_POR(sres[0]),
    .I_VCC_POR(sres[1]), .I_PCI_RESET(sres[2]), .I_HOST_REQ(hreq), .I_SLV_REQ(sreq),
    .I_WRITE_GUARD_INPUT_PIN(pin), .O_HOST_RDATA(hrd), .O_HOST_RVALID(hrv),
    .O_SLV_RDATA(srd), .O_SLV_RVALID(srv), .O_FDC_EN(fen), .O_SER1_EN(s1en),
    .O_SER2_EN(s2en), .O_PAR_EN(pen), .O_FDC_WP(wp), .O_HOST_RO(hro), .O_SLV_RO(sro));
  pdlr_bus_model bus (.i_clk(clk), .i_host_rdata(hrd), .i_host_rvalid(hrv),
    .i_slv_rdata(srd), .i_slv_rvalid(srv), .o_host_req(hreq), .o_slv_req(sreq));
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  function automatic logic [7:0] oexp(input logic [7:0] h, input logic [7:0] s,
    input logic hr, input logic sr);
    logic [7:0] m;
    m = ~(h | s);
    return {m[7], m[6], m[5], m[3], h[0] | s[0], hr, sr, 1'b0};
  endfunction : oexp
  task automatic wr(input bit slv, input logic [7:0] a, input logic [7:0] d);
    bus.xfer(slv, 1'b1, a, d, q, v);
  endtask : wr
  task automatic rd(input bit slv, input logic [7:0] a, input logic [7:0] exp);
    bus.xfer(slv, 1'b0, a, 8'h00, q, v);
    check("rvalid", 8'h01, {7'h00, v});
    check("rdata", exp, q);
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    hv = 8'h00;
    sv = 8'h00;
    check("outs", oexp(hv, sv, 1'b0, 1'b0), outs);
    rd(0, 8'h22, 8'h00);
    rd(0, 8'h01, 8'h00);
    wr(1, 8'h22, 8'hff);
    rd(1, 8'h22, 8'h00);
    // random traffic on both copies, lock kept low
    for (int i = 0; i < 24; i++) begin
      w = 8'($random(seed)) & 8'hfd;
      wr(i[0], i[0] ? 8'h01 : 8'h22, w);
      if (i[0]) sv = w & 8'he9;
      else hv = w & 8'he9;
      rd(i[0], i[0] ? 8'h01 : 8'h22, i[0] ? sv : hv);
      check("outs", oexp(hv, sv, 1'b0, 1'b0), outs);
    end
    wr(0, 8'h40, 8'h04);
    wr(0, 8'h40, 8'h00);
    rd(0, 8'h40, 8'h04);
    pin = 1'b1;
    wr(0, 8'h22, 8'h0a);
    wr(1, 8'h01, 8'h20);
    sv = 8'h20;
    rd(0, 8'h22, hv);
    rd(1, 8'h01, sv);
    check("outs", oexp(hv, sv, 1'b1, 1'b0), outs);
    pin = 1'b0;
    wr(0, 8'h22, 8'h80);
    hv = 8'h80;
    rd(0, 8'h22, hv);
    wr(0, 8'h22, 8'h03);
    hv = 8'h03;
    wr(0, 8'h22, 8'h00);
    wr(1, 8'h01, 8'h00);
    sv = 8'h00;
    rd(0, 8'h22, hv);
    check("outs", oexp(hv, sv, 1'b1, 1'b0), outs);
    wr(1, 8'h01, 8'h0a);
    sv = 8'h0a;
    wr(1, 8'h01, 8'h00);
    rd(1, 8'h01, sv);
    check("outs", oexp(hv, sv, 1'b1, 1'b1), outs);
    // each of the three resets must undo lock and guard select
    for (int k = 0; k < 3; k++) begin
      sres[k] = 1'b1;
      @(negedge clk);
      sres[k] = 1'b0;
      @(negedge clk);
      check("outs", 8'hf0, outs);
      rd(0, 8'h40, 8'h00);
      wr(0, 8'h22, 8'h0a);
      wr(1, 8'h01, 8'h0a);
      wr(0, 8'h40, 8'h04);
    end
    print_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule : pdlr_top_tb
`default_nettype wire
